// ===== shared/smia_pkg.sv
// Purpose: constants for the system-management interrupt aggregator
// Assumes: 8-bit register port, 10 MHz clock
// Notes: register offsets are the printed indices
package smia_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;
	// register indices
	localparam logic [7:0] OFS_EN_FIRST = 8'hb4;
	localparam logic [7:0] OFS_EN_SECOND = 8'hb5;
	localparam logic [7:0] OFS_PEND_FIRST = 8'hb6;
	localparam logic [7:0] OFS_PEND_SECOND = 8'hb7;
	localparam logic [7:0] OFS_STANDBY = 8'hb8;
	localparam logic [7:0] OFS_PIN_FUNC = 8'hc0;
	localparam logic [7:0] OFS_MEDIA_CHG = 8'hc1;
	// reset values
	localparam logic [7:0] RST_EN_FIRST = 8'h00;
	localparam logic [7:0] RST_EN_SECOND = 8'h00;
	localparam logic [7:0] RST_STANDBY = 8'h00;
	localparam logic [7:0] RST_PIN_FUNC = 8'h06;
	localparam logic [7:0] RST_MEDIA_CHG = 8'h00;
	// writable bit masks
	localparam logic [7:0] MASK_EN_FIRST = 8'h9e;
	localparam logic [7:0] MASK_EN_SECOND = 8'hd7;
	localparam logic [7:0] MASK_PIN_FUNC = 8'h1f;
	localparam logic [7:0] MASK_MEDIA_CHG = 8'h03;
	// field positions, first enable / pending
	localparam int unsigned BIT_PARALLEL = 1;
	localparam int unsigned BIT_UART2 = 2;
	localparam int unsigned BIT_UART1 = 3;
	localparam int unsigned BIT_FLOPPY = 4;
	localparam int unsigned BIT_WATCHDOG = 7;
	// field positions, second enable / pending
	localparam int unsigned BIT_MOUSE = 0;
	localparam int unsigned BIT_KEYBOARD = 1;
	localparam int unsigned BIT_INFRARED = 2;
	localparam int unsigned BIT_KBC_PORT = 4;
	localparam int unsigned BIT_SERIRQ_ROUTE = 6;
	localparam int unsigned BIT_PIN_ROUTE = 7;
	// pin function fields
	localparam int unsigned BIT_IR_MODE = 0;
	localparam int unsigned BIT_DMA3 = 1;
	localparam int unsigned BIT_SERIRQ_SEL = 2;
	localparam int unsigned BIT_KBC_SEL = 3;
	localparam int unsigned BIT_ALT_ALT_INFRARED_RECEIVE_PIN_SEL = 4;
	// number of bit positions in each pending register
	localparam int unsigned N_SRC = 8;
endpackage : smia_pkg

// ===== shared/smia_ir_if.sv
// Purpose: carries the infrared receive path to the activity detector
// Assumes: single clock domain
// Notes: receive level is already synchronised
`timescale 1ns/1ps
interface smia_ir_if;
	logic rx_level;
	logic activity;
	modport src (output rx_level, input activity);
	modport det (input rx_level, output activity);
endinterface : smia_ir_if

// ===== hdl/smia_ir_activity.sv
// Purpose: one-cycle pulse on any edge of the selected infrared receive level
// Assumes: input already passed two flip-flops
// Notes: first sample after reset never counts as an edge
`timescale 1ns/1ps
module smia_ir_activity (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	smia_ir_if.det ir
);
	logic prev_r;
	logic primed_r;

	// remember the last level; primed blocks a false edge from reset value
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prev_r <= 1'b0;
			primed_r <= 1'b0;
		end else if (ce_i) begin
			prev_r <= ir.rx_level;
			primed_r <= 1'b1;
		end
	end

	// either direction counts as activity
	assign ir.activity = ce_i & primed_r & (prev_r ^ ir.rx_level);
endmodule : smia_ir_activity

// ===== hdl/smia_top.sv
// Purpose: group system-management interrupt aggregator with its registers
// Assumes: sources are levels from other blocks on clk_i, ir pins are asynchronous
// Notes: read data stand in the cycle after the read strobe
`timescale 1ns/1ps
module smia_top (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// register port
	input wire logic [smia_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [smia_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [smia_pkg::DATA_W-1:0] reg_rdata_o,
	// request levels from sibling blocks, same clock
	input wire logic parallel_port_req_i,
	input wire logic second_uart_req_i,
	input wire logic first_uart_req_i,
	input wire logic floppy_req_i,
	input wire logic watchdog_req_i,
	input wire logic mouse_req_i,
	input wire logic keyboard_req_i,
	input wire logic kbc_port_output_req_i,
	// location mux bit held in the serial port 2 option register
	input wire logic ir_location_alt_i,
	// receive pins, asynchronous
	input wire logic second_serial_receive_pin_i,
	input wire logic alt_infrared_receive_pin_i,
	// group interrupt outputs
	output logic sysmgmt_irq_out_o,
	output logic sysmgmt_irq_out_oe_o,
	output logic serirq_smi_req_o,
	output logic smi_group_active_o,
	// pin function selects to the pin mux
	output logic [4:0] pin_function_o,
	output logic [1:0] media_change_override_o
);
	import smia_pkg::*;

	logic [7:0] en_first_r;
	logic [7:0] en_second_r;
	logic [7:0] standby_r;
	logic [7:0] pin_func_r;
	logic [7:0] media_chg_r;
	logic ir_pending_r;
	logic [7:0] rdata_r;
	logic irq_r;
	logic [1:0] rx2_sync_r;
	logic [1:0] alt_sync_r;

	smia_ir_if ir_bus ();

	// register write decode, and the read strobe of the second pending register
	wire wr_en_first = ce_i & reg_wr_i & (reg_addr_i == OFS_EN_FIRST);
	wire wr_en_second = ce_i & reg_wr_i & (reg_addr_i == OFS_EN_SECOND);
	wire wr_standby = ce_i & reg_wr_i & (reg_addr_i == OFS_STANDBY);
	wire wr_pin_func = ce_i & reg_wr_i & (reg_addr_i == OFS_PIN_FUNC);
	wire wr_media_chg = ce_i & reg_wr_i & (reg_addr_i == OFS_MEDIA_CHG);
	wire rd_pend_second = ce_i & reg_rd_i & (reg_addr_i == OFS_PEND_SECOND);

	// pending views follow their sources directly, except the infrared bit, which a read of the second pending register clears
	wire [7:0] pend_first = {watchdog_req_i, 2'b00, floppy_req_i, first_uart_req_i,
		second_uart_req_i, parallel_port_req_i, 1'b0};
	wire [7:0] pend_second = {3'b000, kbc_port_output_req_i, 1'b0, ir_pending_r,
		keyboard_req_i, mouse_req_i};

	// gating of each source by its enable bit
	wire [7:0] gated_first = pend_first & en_first_r & MASK_EN_FIRST;
	wire [7:0] src_mask_second = 8'h17; // mouse, keyboard, infrared, port output
	wire [7:0] gated_second = pend_second & en_second_r & src_mask_second;
	wire group_nxt = (|gated_first) | (|gated_second);

	// input synchronisers for both receive pins
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx2_sync_r <= 2'b11;
			alt_sync_r <= 2'b11;
		end else if (ce_i) begin
			rx2_sync_r <= {rx2_sync_r[0], second_serial_receive_pin_i};
			alt_sync_r <= {alt_sync_r[0], alt_infrared_receive_pin_i};
		end
	end

	// watch only the pin after the location mux
	assign ir_bus.rx_level = ir_location_alt_i ? alt_sync_r[1] : rx2_sync_r[1];

	smia_ir_activity u_ir_activity (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.ir(ir_bus)
	);

	// infrared activity flag; a new edge wins over the read that clears it
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ir_pending_r <= 1'b0;
		end else if (ir_bus.activity) begin
			ir_pending_r <= 1'b1;
		end else if (rd_pend_second) begin
			ir_pending_r <= 1'b0;
		end
	end

	// enable registers; reserved bits stay zero
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			en_first_r <= RST_EN_FIRST;
			en_second_r <= RST_EN_SECOND;
		end else begin
			if (wr_en_first) en_first_r <= reg_wdata_i & MASK_EN_FIRST;
			if (wr_en_second) en_second_r <= reg_wdata_i & MASK_EN_SECOND;
		end
	end

	// pin function, standby and media change registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_func_r <= RST_PIN_FUNC;
			standby_r <= RST_STANDBY;
			media_chg_r <= RST_MEDIA_CHG;
		end else begin
			if (wr_pin_func) pin_func_r <= reg_wdata_i & MASK_PIN_FUNC;
			if (wr_standby) standby_r <= reg_wdata_i;
			if (wr_media_chg) media_chg_r <= reg_wdata_i & MASK_MEDIA_CHG;
		end
	end

	// registered group level keeps the pin glitch free
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_r <= 1'b0;
		end else if (ce_i) begin
			irq_r <= group_nxt;
		end
	end

	// read mux; unmapped indices read zero
	logic [7:0] rd_mux;
	always_comb begin
		case (reg_addr_i)
			OFS_EN_FIRST: rd_mux = en_first_r;
			OFS_EN_SECOND: rd_mux = en_second_r;
			OFS_PEND_FIRST: rd_mux = pend_first;
			OFS_PEND_SECOND: rd_mux = pend_second;
			OFS_STANDBY: rd_mux = standby_r;
			OFS_PIN_FUNC: rd_mux = pin_func_r;
			OFS_MEDIA_CHG: rd_mux = media_chg_r;
			default: rd_mux = 8'h00;
		endcase
	end

	// read data stand for exactly one cycle after the strobe
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_r <= 8'h00;
		end else if (ce_i) begin
			rdata_r <= reg_rd_i ? rd_mux : 8'h00;
		end
	end

	assign reg_rdata_o = rdata_r;
	// dedicated pin is active low and floats when routing is off
	assign sysmgmt_irq_out_oe_o = en_second_r[BIT_PIN_ROUTE];
	assign sysmgmt_irq_out_o = ~irq_r;
	assign serirq_smi_req_o = irq_r & en_second_r[BIT_SERIRQ_ROUTE];
	assign smi_group_active_o = irq_r;
	assign pin_function_o = pin_func_r[4:0];
	assign media_change_override_o = media_chg_r[1:0];
endmodule : smia_top

// ===== tb/smia_chk.sv
// Purpose: port-level assertions for the interrupt aggregator
// Assumes: ce_i high whenever the bus is used
// Notes: bound to smia_top from the bench
`timescale 1ns/1ps
module smia_chk (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic sysmgmt_irq_out_o,
	input wire logic sysmgmt_irq_out_oe_o,
	input wire logic serirq_smi_req_o,
	input wire logic smi_group_active_o,
	input wire logic [4:0] pin_function_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// decoded write strobes, ce gates every access
	wire wr_b5 = reg_wr_i && ce_i && reg_addr_i == 8'hb5;
	wire wr_c0 = reg_wr_i && ce_i && reg_addr_i == 8'hc0;
	a_pin_low_true: assert property (sysmgmt_irq_out_o == !smi_group_active_o)
		else $error("pin level not inverse of group");
	a_oe_write: assert property (wr_b5 |=> sysmgmt_irq_out_oe_o == $past(reg_wdata_i[7]))
		else $error("pin enable not taken from write");
	a_oe_steady: assert property ($changed(sysmgmt_irq_out_oe_o) |-> $past(wr_b5))
		else $error("pin enable moved without write");
	a_func_write: assert property (wr_c0 |=> pin_function_o == $past(reg_wdata_i[4:0]))
		else $error("pin function not written");
	a_func_steady: assert property ($changed(pin_function_o) |-> $past(wr_c0))
		else $error("pin function moved without write");
	a_func_read: assert property (reg_rd_i && ce_i && reg_addr_i == 8'hc0
		|=> reg_rdata_o == {3'h0, $past(pin_function_o)})
		else $error("pin function readback wrong");
	a_oe_read: assert property (reg_rd_i && ce_i && reg_addr_i == 8'hb5
		|=> reg_rdata_o[7] == $past(sysmgmt_irq_out_oe_o))
		else $error("pin route bit readback wrong");
	a_rdata_idle: assert property (!$past(reg_rd_i && ce_i) |-> reg_rdata_o == 8'h00)
		else $error("read data outside read slot");
	a_unmapped_zero: assert property (reg_rd_i && reg_addr_i < 8'hb4 |=> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	// main scenarios reached
	c_group: cover property ($rose(smi_group_active_o));
	c_serirq: cover property (serirq_smi_req_o);
	c_pin: cover property (sysmgmt_irq_out_oe_o && !sysmgmt_irq_out_o);
endmodule : smia_chk

// ===== tb/smia_host_model.sv
// Purpose: host side of the group interrupt, pin plus serial stream
// Assumes: pin has a pull-up on the board
// Notes: undriven pin reads high, so no interrupt
`timescale 1ns/1ps
module smia_host_model (
	input wire logic irq_pin_i,
	input wire logic oe_i,
	input wire logic serirq_i,
	output logic smi_seen_o
);
	// floating pin is pulled up, low-true interrupt
	wire pin_level = oe_i ? irq_pin_i : 1'b1;
	assign smi_seen_o = !pin_level || serirq_i;
endmodule : smia_host_model

// ===== tb/tb.sv
// Purpose: self-checking bench for the interrupt aggregator
// Assumes: ce_i held high throughout
// Notes: ir waits cover two sync flops and the edge detector
`timescale 1ns/1ps
module tb;
	import smia_pkg::*;
	logic clk_i = 0, rst_n_i = 0, ce_i = 1, reg_wr_i = 0, reg_rd_i = 0, g, smi_seen;
	logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, p1 = 8'h00, p2 = 8'h00, v;
	// receive pins idle high, matching the synchroniser reset level, so reset makes no false edge
	logic ir_location_alt_i = 0, second_serial_receive_pin_i = 1, alt_infrared_receive_pin_i = 1;
	logic sysmgmt_irq_out_o, sysmgmt_irq_out_oe_o, serirq_smi_req_o, smi_group_active_o;
	logic [4:0] pin_function_o;
	logic [1:0] media_change_override_o;
	int err_total = 0, check_count = 0;
	// source levels follow the pending bit layout
	wire parallel_port_req_i = p1[1], second_uart_req_i = p1[2], first_uart_req_i = p1[3];
	wire floppy_req_i = p1[4], watchdog_req_i = p1[7];
	wire mouse_req_i = p2[0], keyboard_req_i = p2[1], kbc_port_output_req_i = p2[4];
	// rows: enable1, enable2, sources1, sources2
	logic [7:0] rows [4][4] = '{'{8'h82, 8'hd3, 8'h80, 8'h00}, '{8'h1c, 8'h00, 8'h02, 8'h13},
		'{8'h00, 8'h13, 8'h00, 8'h10}, '{8'h9e, 8'h40, 8'h1c, 8'h00}};
	logic [7:0] rst_tab [7][2] = '{'{8'hb4, 8'h00}, '{8'hb5, 8'h00}, '{8'hb6, 8'h00},
		'{8'hb7, 8'h00}, '{8'hb8, 8'h00}, '{8'hc0, 8'h06}, '{8'ha0, 8'h00}};
	smia_top dut (.*);
	smia_host_model host (.irq_pin_i(sysmgmt_irq_out_o), .oe_i(sysmgmt_irq_out_oe_o),
		.serirq_i(serirq_smi_req_o), .smi_seen_o(smi_seen));
	always #50 clk_i = ~clk_i;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1;
		@(posedge clk_i);
		reg_wr_i <= 0;
	endtask : wr
	// data taken in the single cycle it stands
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1;
		@(posedge clk_i);
		reg_rd_i <= 0;
		#1 d = reg_rdata_o;
	endtask : rd
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e) begin
			$display("MISMATCH %s exp %h got %h", n, e, s);
			err_total++;
		end
	endtask : chk
	task automatic ir_wait();
		repeat (5) @(posedge clk_i);
	endtask : ir_wait
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : wrap_up
	initial begin
		#300000;
		err_total++;
		wrap_up();
	end
	initial begin
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1;
		foreach (rst_tab[i]) begin
			rd(rst_tab[i][0], v);
			chk("reset", v, rst_tab[i][1]);
		end
		$display("test reset done");
		foreach (rows[i]) begin
			wr(8'hb4, rows[i][0]);
			wr(8'hb5, rows[i][1]);
			@(posedge clk_i);
			p1 <= rows[i][2];
			p2 <= rows[i][3];
			repeat (3) @(posedge clk_i);
			#1 g = |(rows[i][0] & rows[i][2] & 8'h9e) | |(rows[i][1] & rows[i][3] & 8'h13);
			chk("group", smi_group_active_o, g);
			chk("serirq", serirq_smi_req_o, g & rows[i][1][6]);
			chk("pin_oe", sysmgmt_irq_out_oe_o, rows[i][1][7]);
			chk("host", smi_seen, g & (rows[i][1][7] | rows[i][1][6]));
			rd(8'hb6, v);
			chk("pend1", v, rows[i][2] & 8'h9e);
			rd(8'hb7, v);
			chk("pend2", v, rows[i][3] & 8'h13);
			rd(8'hb4, v);
			chk("en1", v, rows[i][0] & 8'h9e);
			rd(8'hb5, v);
			chk("en2", v, rows[i][1] & 8'hd7);
		end
		$display("test rows done");
		// software cannot clear first pending by a write, only the source can
		wr(8'hb6, 8'hff);
		rd(8'hb6, v);
		chk("pend_wr", v, 8'h1c);
		@(posedge clk_i);
		p1 <= 8'h00;
		repeat (3) @(posedge clk_i);
		rd(8'hb6, v);
		chk("pend_src", v, 8'h00);
		wr(8'hc0, 8'hff);
		rd(8'hc0, v);
		chk("c0_rsvd", v, 8'h1f);
		rst_n_i <= 0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1;
		rd(8'hc0, v);
		chk("c0_rst", v, 8'h06);
		$display("test regs done");
		wr(8'hb5, 8'h04);
		second_serial_receive_pin_i <= 0;
		ir_wait();
		#1 chk("ir_grp", smi_group_active_o, 1'b1);
		rd(8'hb7, v);
		chk("ir_set", v, 8'h04);
		rd(8'hb7, v);
		chk("ir_clr", v, 8'h00);
		// switching the mux may show a sync edge, so one read flushes the flag
		alt_infrared_receive_pin_i <= 0;
		ir_location_alt_i <= 1;
		ir_wait();
		rd(8'hb7, v);
		second_serial_receive_pin_i <= 1;
		ir_wait();
		rd(8'hb7, v);
		chk("ir_unsel", v, 8'h00);
		alt_infrared_receive_pin_i <= 1;
		ir_wait();
		rd(8'hb7, v);
		chk("ir_alt", v, 8'h04);
		$display("test ir done");
		wrap_up();
	end
endmodule : tb
bind smia_top smia_chk chk_u (.*);
